/* hw/dbl_defs.svh */
`ifndef DBL_DEFS_SVH
`define DBL_DEFS_SVH

// Clock rate of mclk in MHz.
`define DBL_CLK_MHZ       250

// Pin timing figures in nanoseconds.
`define DBL_T_SETUP_NS    60
`define DBL_T_BYTE_WR_NS  60
`define DBL_T_UPD_WR_NS   70
`define DBL_T_HOLD_NS     20

// Least times round up to whole clock cycles.
`define DBL_NS2CYC(ns)    ((((ns) * `DBL_CLK_MHZ) + 999) / 1000)

`define DBL_SETUP_CYC     `DBL_NS2CYC(`DBL_T_SETUP_NS)
`define DBL_BYTE_WR_CYC   `DBL_NS2CYC(`DBL_T_BYTE_WR_NS)
`define DBL_UPD_WR_CYC    `DBL_NS2CYC(`DBL_T_UPD_WR_NS)
`define DBL_HOLD_CYC      `DBL_NS2CYC(`DBL_T_HOLD_NS)

// Width of the pulse timer count.
`define DBL_TMR_W         8

`endif

/* hw/dbl_host.sv */
`timescale 1ns/100ps
`include "dbl_defs.svh"

// Notes on behaviour
// RULE1: Chip select with only the upper enable low loads the upper byte into the first rank.
// RULE2: Chip select with only the lower enable low loads the lower byte into the first rank.
// RULE3: Chip select with only the update strobe low copies the first rank to the converter.
// RULE4: With all four controls low every latch is transparent and the output follows the pins.
// RULE5: Byte enables act only under chip select; otherwise every latch holds.
// RULE6: All latch controls are level-sensitive and active low.
// RULE7: The converter may load in its own cycle or together with either byte enable.
// RULE8: Several converters may be updated at once by one shared update strobe.
// RULE9: The host raises the strobes before changing data, or uses a second write cycle.
// RULE10: The host puts its write strobe on the byte enables and its address on chip select.
// RULE11: A host that writes the whole word at once may hold the update strobe low.
// RULE12: An 8-bit host writes two bytes and ties the update to the second byte enable.
// RULE13: An 8-bit host selects the upper or lower latch with its own enable.
// RULE14: For short strobes the host pulses the byte enables and keeps chip select as address.
// RULE15: The converter code is offset binary, all zeros lowest and all ones highest.
// RULE16: Upper latch holds bits 15 to 8 and the lower latch bits 7 to 0 of the word.
module dbl_host
    import dbl_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        wide_bus,
    input  wire logic        cmd_valid,
    input  wire dbl_cmd_t    cmd,
    output logic             cmd_ready,
    output logic             cmd_done,
    output logic             chip_select_n,
    output logic             upper_byte_load_n,
    output logic             lower_byte_load_n,
    output logic             converter_update_n,
    output logic [15:0]      dac_data
);

    dbl_state_t            state_q;
    dbl_cmd_t              cmd_q;
    logic                  ph_q;
    logic                  expired;
    logic                  tmr_load;
    logic [`DBL_TMR_W-1:0] tmr_len;
    dbl_phase_t            cur_ph;
    dbl_phase_t            nxt_ph;
    dbl_phase_t            new_ph;
    logic                  upd_rest;

    // With a wide bus the update strobe rests low so the converter is transparent.
    assign upd_rest = ~wide_bus; // RULE11

    // Describe phase ph of a request; in DBL_MODE_HI_LO and DBL_MODE_LO_HI the update joins the second byte's enable.
    function automatic dbl_phase_t phase_of(input dbl_mode_t mode, input logic ph,
                                            input logic rest);
        dbl_phase_t p;
        p = '{1'b1, 1'b1, rest, DBL_LANE_WORD, 1'b1};
        case (mode)
            DBL_MODE_WORD:
            begin
                p.upper_byte_load_n = 1'b0; // RULE10
                p.lower_byte_load_n = 1'b0;
            end
            DBL_MODE_HI_LO:
            begin
                p.upper_byte_load_n = ph; // RULE13
                p.lower_byte_load_n = ~ph;
                p.converter_update_n = ph ? 1'b0 : rest; // RULE12 RULE7
                p.lane = ph ? DBL_LANE_LO : DBL_LANE_HI;
                p.last = ph;
            end
            DBL_MODE_LO_HI:
            begin
                p.upper_byte_load_n = ~ph; // RULE13
                p.lower_byte_load_n = ph;
                p.converter_update_n = ph ? 1'b0 : rest; // RULE12 RULE7
                p.lane = ph ? DBL_LANE_HI : DBL_LANE_LO;
                p.last = ph;
            end
            DBL_MODE_BYTES:
            begin
                p.upper_byte_load_n = ph; // RULE1
                p.lower_byte_load_n = ~ph; // RULE2
                p.lane = ph ? DBL_LANE_LO : DBL_LANE_HI;
                p.last = ph;
            end
            DBL_MODE_UPDATE:
            begin
                p.converter_update_n = 1'b0; // RULE3 RULE8
            end
            DBL_MODE_HI:
            begin
                p.upper_byte_load_n = 1'b0; // RULE1
                p.lane = DBL_LANE_HI;
            end
            DBL_MODE_LO:
            begin
                p.lower_byte_load_n = 1'b0; // RULE2
                p.lane = DBL_LANE_LO;
            end
            default:
            begin
                p.last = 1'b1;
            end
        endcase
        return p;
    endfunction : phase_of

    // An 8-bit hookup wires both halves of the bus together, so a byte goes on both lanes.
    function automatic logic [15:0] lanes_of(input dbl_lane_t lane, input logic [15:0] w);
        logic [15:0] d;
        case (lane)
            DBL_LANE_HI: d = {w[15:8], w[15:8]}; // RULE16
            DBL_LANE_LO: d = {w[7:0], w[7:0]}; // RULE16
            default:     d = w; // RULE15
        endcase
        return d;
    endfunction : lanes_of

    assign cur_ph = phase_of(cmd_q.mode, ph_q, upd_rest);
    assign nxt_ph = phase_of(cmd_q.mode, 1'b1, upd_rest);
    assign new_ph = phase_of(cmd.mode, 1'b0, upd_rest);

    // Timer reloads at every state step except the last hold; the update alone needs the longer pulse.
    always_comb
    begin
        tmr_load = 1'b0;
        tmr_len  = `DBL_TMR_W'(`DBL_SETUP_CYC);
        case (state_q)
            DBL_ST_IDLE:
            begin
                tmr_load = cmd_valid && cmd_ready;
            end
            DBL_ST_SETUP:
            begin
                tmr_load = expired;
                tmr_len  = (cur_ph.upper_byte_load_n && cur_ph.lower_byte_load_n)
                         ? `DBL_TMR_W'(`DBL_UPD_WR_CYC) : `DBL_TMR_W'(`DBL_BYTE_WR_CYC);
            end
            DBL_ST_STROBE:
            begin
                tmr_load = expired;
                tmr_len  = `DBL_TMR_W'(`DBL_HOLD_CYC);
            end
            DBL_ST_HOLD:
            begin
                tmr_load = expired && !cur_ph.last;
            end
            default:
            begin
                tmr_load = 1'b0;
            end
        endcase
    end

    dbl_pulse_timer u_timer
    (
        .mclk    (mclk),
        .rst     (rst),
        .load    (tmr_load),
        .len     (tmr_len),
        .expired (expired)
    );

    // Sequencer: setup under chip select, strobe, hold, then next phase or finish.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_q <= DBL_ST_IDLE;
            ph_q    <= 1'b0;
            cmd_q   <= '{DBL_MODE_WORD, 16'h0000};
        end
        else
        begin
            case (state_q)
                DBL_ST_IDLE:
                begin
                    if (cmd_valid && cmd_ready)
                    begin
                        cmd_q   <= cmd;
                        ph_q    <= 1'b0;
                        state_q <= DBL_ST_SETUP;
                    end
                end
                DBL_ST_SETUP:
                begin
                    if (expired)
                    begin
                        state_q <= DBL_ST_STROBE;
                    end
                end
                DBL_ST_STROBE:
                begin
                    if (expired)
                    begin
                        state_q <= DBL_ST_HOLD;
                    end
                end
                DBL_ST_HOLD:
                begin
                    if (expired)
                    begin
                        ph_q    <= 1'b1;
                        state_q <= cur_ph.last ? DBL_ST_IDLE : DBL_ST_SETUP; // RULE9
                    end
                end
                default:
                begin
                    state_q <= DBL_ST_IDLE;
                end
            endcase
        end
    end

    // Pin drive: data changes only while both byte enables are high, so nothing leaks through.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            chip_select_n      <= 1'b1;
            upper_byte_load_n  <= 1'b1;
            lower_byte_load_n  <= 1'b1;
            converter_update_n <= 1'b1;
            dac_data           <= 16'h0000;
        end
        else
        begin
            case (state_q)
                DBL_ST_IDLE:
                begin
                    converter_update_n <= upd_rest; // RULE11
                    if (cmd_valid && cmd_ready)
                    begin
                        chip_select_n <= 1'b0; // RULE10 RULE5
                        dac_data      <= lanes_of(new_ph.lane, cmd.word);
                    end
                end
                DBL_ST_SETUP:
                begin
                    if (expired)
                    begin
                        upper_byte_load_n  <= cur_ph.upper_byte_load_n; // RULE6 RULE14
                        lower_byte_load_n  <= cur_ph.lower_byte_load_n;
                        converter_update_n <= cur_ph.converter_update_n; // RULE4
                    end
                end
                DBL_ST_STROBE:
                begin
                    if (expired)
                    begin
                        upper_byte_load_n  <= 1'b1; // RULE9
                        lower_byte_load_n  <= 1'b1;
                        converter_update_n <= upd_rest;
                    end
                end
                DBL_ST_HOLD:
                begin
                    if (expired && cur_ph.last)
                    begin
                        chip_select_n <= 1'b1;
                    end
                    else if (expired)
                    begin
                        dac_data <= lanes_of(nxt_ph.lane, cmd_q.word); // RULE9
                    end
                end
                default:
                begin
                    chip_select_n <= 1'b1;
                end
            endcase
        end
    end

    // User handshake: ready while idle, done for one cycle as chip select rises.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cmd_ready <= 1'b1;
            cmd_done  <= 1'b0;
        end
        else
        begin
            cmd_done <= (state_q == DBL_ST_HOLD) && expired && cur_ph.last;
            if (state_q == DBL_ST_IDLE && cmd_valid && cmd_ready)
            begin
                cmd_ready <= 1'b0;
            end
            else if (state_q == DBL_ST_HOLD && expired && cur_ph.last)
            begin
                cmd_ready <= 1'b1;
            end
        end
    end

endmodule : dbl_host

/* hw/dbl_pkg.sv */
package dbl_pkg;

    // Kinds of write sequence that the controller can run.
    typedef enum logic [2:0]
    {
        DBL_MODE_WORD,
        DBL_MODE_HI_LO,
        DBL_MODE_LO_HI,
        DBL_MODE_BYTES,
        DBL_MODE_UPDATE,
        DBL_MODE_HI,
        DBL_MODE_LO
    } dbl_mode_t;

    // One request from the user side.
    typedef struct packed
    {
        dbl_mode_t   mode;
        logic [15:0] word;
    } dbl_cmd_t;

    // Lane selection for the data pins during one phase.
    typedef enum logic [1:0]
    {
        DBL_LANE_WORD,
        DBL_LANE_HI,
        DBL_LANE_LO
    } dbl_lane_t;

    // Strobes and data lanes for one write phase.
    typedef struct packed
    {
        logic      upper_byte_load_n;
        logic      lower_byte_load_n;
        logic      converter_update_n;
        dbl_lane_t lane;
        logic      last;
    } dbl_phase_t;

    // Controller sequencing states.
    typedef enum logic [1:0]
    {
        DBL_ST_IDLE,
        DBL_ST_SETUP,
        DBL_ST_STROBE,
        DBL_ST_HOLD
    } dbl_state_t;

endpackage : dbl_pkg

/* hw/dbl_pulse_timer.sv */
`timescale 1ns/100ps
`include "dbl_defs.svh"

// Counts out one interval; expired pulses for one cycle when it ends.
module dbl_pulse_timer
    import dbl_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  load,
    input  wire logic [`DBL_TMR_W-1:0] len,
    output logic                       expired
);

    logic [`DBL_TMR_W-1:0] cnt_q;
    logic                  busy_q;

    // A load restarts the count even while busy, so the sequencer owns timing.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cnt_q   <= '0;
            busy_q  <= 1'b0;
            expired <= 1'b0;
        end
        else if (load)
        begin
            cnt_q   <= len - `DBL_TMR_W'(1);
            busy_q  <= 1'b1;
            expired <= 1'b0;
        end
        else if (busy_q && cnt_q == '0)
        begin
            busy_q  <= 1'b0;
            expired <= 1'b1;
        end
        else
        begin
            cnt_q   <= busy_q ? cnt_q - `DBL_TMR_W'(1) : cnt_q;
            expired <= 1'b0;
        end
    end

endmodule : dbl_pulse_timer

/* sim/dbl_dev_model.sv */
`timescale 1ns/100ps

// Behavioural double-buffered latches; every latch is level-sensitive.
module dbl_dev_model
(
    input wire logic         chip_select_n,
    input wire logic         upper_byte_load_n,
    input wire logic         lower_byte_load_n,
    input wire logic         converter_update_n,
    input wire logic [15:0]  data_in,
    output logic     [15:0]  dac_code
);
    logic [7:0] hi_q;
    logic [7:0] lo_q;

    // First rank; with chip select high nothing opens, so the byte enables alone do nothing.
    always_latch
    begin
        if (!chip_select_n && !upper_byte_load_n)
            hi_q <= data_in[15:8];
        if (!chip_select_n && !lower_byte_load_n)
            lo_q <= data_in[7:0];
    end

    // Converter register; open together with the first rank it makes the path transparent.
    always_latch
    begin
        if (!chip_select_n && !converter_update_n)
            dac_code <= {hi_q, lo_q};
    end
endmodule : dbl_dev_model

/* sim/dbl_host_props.sv */
`timescale 1ns/100ps

// Watches the device-side pins of the host controller against its command stream.
module dbl_host_props
    import dbl_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        wide_bus,
    input wire logic        cmd_valid,
    input wire dbl_cmd_t    cmd,
    input wire logic        cmd_ready,
    input wire logic        cmd_done,
    input wire logic        chip_select_n,
    input wire logic        upper_byte_load_n,
    input wire logic        lower_byte_load_n,
    input wire logic        converter_update_n,
    input wire logic [15:0] dac_data
);
    logic      take;
    dbl_mode_t mode_q;

    // The user may change cmd once it is taken, so the running mode is kept here.
    assign take = cmd_valid && cmd_ready;
    always_ff @(posedge mclk)
    begin
        if (rst)
            mode_q <= DBL_MODE_WORD;
        else if (take)
            mode_q <= cmd.mode;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_byte_on;
        !upper_byte_load_n || !lower_byte_load_n;
    endsequence
    sequence s_last_byte;
        ($fell(lower_byte_load_n) && mode_q == DBL_MODE_HI_LO)
        || ($fell(upper_byte_load_n) && mode_q == DBL_MODE_LO_HI);
    endsequence

    a_en_under_cs: assert property (s_byte_on |-> !chip_select_n)
        else $error("byte enable low without chip select");
    a_take_selects: assert property (take |=> !chip_select_n && !cmd_ready)
        else $error("accepted command did not select the device");
    a_word_len: assert property (take && cmd.mode inside
        {DBL_MODE_WORD, DBL_MODE_HI, DBL_MODE_LO} |-> ##[38:39] cmd_done)
        else $error("single phase command length wrong");
    a_upd_len: assert property (take && cmd.mode == DBL_MODE_UPDATE
        |-> ##[41:42] cmd_done)
        else $error("update command length wrong");
    a_pair_len: assert property (take && cmd.mode inside
        {DBL_MODE_HI_LO, DBL_MODE_LO_HI, DBL_MODE_BYTES} |-> ##[76:77] cmd_done)
        else $error("two byte command length wrong");
    a_pair_update: assert property (s_last_byte |-> !converter_update_n)
        else $error("update not with second byte enable");
    a_bytes_no_upd: assert property (!chip_select_n && !wide_bus
        && mode_q == DBL_MODE_BYTES |-> converter_update_n)
        else $error("update strobed during group load");
    a_one_lane: assert property (!chip_select_n && mode_q != DBL_MODE_WORD
        |-> upper_byte_load_n || lower_byte_load_n)
        else $error("both byte enables low in a byte mode");
    a_lane_copy: assert property ((!upper_byte_load_n || !lower_byte_load_n)
        && mode_q != DBL_MODE_WORD |-> dac_data[15:8] == dac_data[7:0])
        else $error("byte lanes differ during byte phase");
    a_data_held: assert property (s_byte_on ##1 s_byte_on |-> $stable(dac_data))
        else $error("data changed under an open enable");
    a_upd_rest: assert property (cmd_ready && $past(cmd_ready) && !$past(rst)
        |-> converter_update_n == !$past(wide_bus))
        else $error("idle update level wrong");
endmodule : dbl_host_props

bind dbl_host dbl_host_props u_props
(
    .mclk               (mclk),
    .rst                (rst),
    .wide_bus           (wide_bus),
    .cmd_valid          (cmd_valid),
    .cmd                (cmd),
    .cmd_ready          (cmd_ready),
    .cmd_done           (cmd_done),
    .chip_select_n      (chip_select_n),
    .upper_byte_load_n  (upper_byte_load_n),
    .lower_byte_load_n  (lower_byte_load_n),
    .converter_update_n (converter_update_n),
    .dac_data           (dac_data)
);

/* sim/dbl_host_tb_top.sv */
`timescale 1ns/100ps

module dbl_host_tb_top
    import dbl_pkg::*;
;
    logic        mclk;
    logic        rst;
    logic        wide_bus;
    logic        cmd_valid;
    dbl_cmd_t    cmd;
    logic        cmd_ready;
    logic        cmd_done;
    logic        chip_select_n;
    logic        upper_byte_load_n;
    logic        lower_byte_load_n;
    logic        converter_update_n;
    logic [15:0] dac_data;
    logic [15:0] dac_code;
    int          n_mismatch;
    int          n_checks;
    int          cyc;

    dbl_host DUT (.mclk(mclk), .rst(rst), .wide_bus(wide_bus), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .chip_select_n(chip_select_n),
        .upper_byte_load_n(upper_byte_load_n), .lower_byte_load_n(lower_byte_load_n),
        .converter_update_n(converter_update_n), .dac_data(dac_data));

    dbl_dev_model DEV (.chip_select_n(chip_select_n), .upper_byte_load_n(upper_byte_load_n),
        .lower_byte_load_n(lower_byte_load_n), .converter_update_n(converter_update_n),
        .data_in(dac_data), .dac_code(dac_code));

    // Free-running clock at 250 MHz.
    always #2 mclk = ~mclk;

    // A hung handshake would stall the run, so a cycle ceiling ends it.
    always @(posedge mclk)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Runs one command, then checks its length and the converter code that results.
    task automatic run(dbl_mode_t m, logic [15:0] w, logic [15:0] exp_out);
        int n;
        int len;
        n = 0;
        len = (m == DBL_MODE_UPDATE) ? 41 :
              (m inside {DBL_MODE_HI_LO, DBL_MODE_LO_HI, DBL_MODE_BYTES}) ? 76 : 38;
        cmd = '{mode: m, word: w};
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1)
            @(posedge mclk) #1;
        @(posedge mclk);
        #1 cmd_valid = 1'b0;
        while (cmd_done !== 1'b1 && n < 200)
        begin
            @(posedge mclk);
            #1 n++;
        end
        check("length", len[15:0], n[15:0]);
        check("code", exp_out, dac_code);
    endtask : run

    task automatic t_reset;
        check("ready", 16'h0001, {15'h0000, cmd_ready});
        check("pins", 16'h000F, {12'h000, chip_select_n, upper_byte_load_n,
            lower_byte_load_n, converter_update_n});
    endtask : t_reset

    task automatic t_narrow;
        run(DBL_MODE_HI_LO, 16'h0000, 16'h0000);
        run(DBL_MODE_LO_HI, 16'hFFFF, 16'hFFFF);
        run(DBL_MODE_WORD, 16'h1234, 16'hFFFF);
        run(DBL_MODE_UPDATE, 16'h0000, 16'h1234);
    endtask : t_narrow

    task automatic t_single;
        run(DBL_MODE_HI, 16'hA5C3, 16'h1234);
        run(DBL_MODE_LO, 16'h5A3C, 16'h1234);
        run(DBL_MODE_UPDATE, 16'h0000, 16'hA53C);
    endtask : t_single

    task automatic t_group;
        run(DBL_MODE_BYTES, 16'h8080, 16'hA53C);
        run(DBL_MODE_UPDATE, 16'h0000, 16'h8080);
    endtask : t_group

    task automatic t_wide;
        wide_bus = 1'b1;
        repeat (3) @(posedge mclk);
        #1 check("rest", 16'h0000, {15'h0000, converter_update_n});
        run(DBL_MODE_WORD, 16'h4321, 16'h4321);
        run(DBL_MODE_UPDATE, 16'h0000, 16'h4321);
    endtask : t_wide

    task automatic close_out;
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    // Reset for eight cycles, then the scenarios in turn.
    initial
    begin
        mclk = 1'b0;
        rst = 1'b1;
        wide_bus = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        n_mismatch = 0;
        n_checks = 0;
        cyc = 0;
        repeat (8) @(posedge mclk);
        #1 rst = 1'b0;
        t_reset();
        t_narrow();
        t_single();
        t_group();
        t_wide();
        close_out();
    end
endmodule : dbl_host_tb_top
